// ===== core/dac_ctrl_defines.vh
`ifndef DAC_CTRL_DEFINES_VH
`define DAC_CTRL_DEFINES_VH

`define AM_A32_NP 6'h09
`define AM_A32_SU 6'h0D
`define AM_A24_NP 6'h39
`define AM_A24_SU 6'h3D
`define AM_A16_NP 6'h29
`define AM_A16_SU 6'h2D

`define OFS_CTRL 7'h40
`define OFS_STAT 7'h42
`define OFS_CMD 7'h44

`define CTL_FMT 0
`define CTL_SYNC 1
`define CTL_RNG_LO 2
`define CTL_RNG_HI 4
`define CTL_TSRC 5
`define CTL_TPOL 6
`define CTL_ONLINE 7
`define CTL_LED 8
`define CTL_RESET 8'h00

`define CMD_TRIG 0
`define CMD_CAL 1

`define RESP_OK 2'h0
`define RESP_DECERR 2'h3

`define CAL_CODE_LO 12'h000
`define CAL_CODE_HI 12'hFFF
`define ADC_LO_NOM 16'h0000
`define ADC_HI_NOM 16'hFFF0
`define OFS_LIM 16'h0200
`define GERR_LIM 16'h0800

`define CODE_MSB 12'h800
`define CODE_MAX 17'h00FFF
`define GAIN_FRAC 16
`define ADC_TO_DAC 4

`define CLK_PERIOD_NS 100
`define TRIG_MIN_NS 1000
`define TRIG_MIN_CYC ((`TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/code_correct.v
`include "dac_ctrl_defines.vh"

module code_correct
(
  // Stored channel code and format
  input wire [15:0] code,
  input wire twos_fmt,
  // Calibration entry, converter counts
  input wire [15:0] ofs,
  input wire [15:0] gerr,
  // Corrected converter code
  output reg [11:0] corr
);

  wire [11:0] ub;
  wire signed [28:0] prod;
  wire signed [28:0] prod_sh;
  wire signed [15:0] ofs_sh;
  wire signed [16:0] sum;

  // Two's complement becomes offset binary by flipping the sign bit
  assign ub = twos_fmt ? (code[11:0] ^ `CODE_MSB) : code[11:0];
  assign prod = $signed({1'b0, ub}) * $signed(gerr);
  assign prod_sh = prod >>> `GAIN_FRAC;
  assign ofs_sh = $signed(ofs) >>> `ADC_TO_DAC;
  assign sum = $signed({5'h00, ub}) + prod_sh[16:0] - $signed({ofs_sh[15], ofs_sh});

  // Saturate so a large correction never wraps the output
  always @*
  begin
    if (sum[16])
      corr = 12'h000;
    else if (sum > $signed(`CODE_MAX))
      corr = 12'hFFF;
    else
      corr = sum[11:0];
  end

endmodule // code_correct

// ===== core/dac_output_ctrl.v
`include "dac_ctrl_defines.vh"

module dac_output_ctrl #(
  parameter NCH = 32,
  parameter CHW = 5,
  parameter NRANGES = 6
)
(
  // Clock, reset, enable
  input wire core_clk,
  input wire nrst,
  input wire ce,
  // Avalon-MM slave with bus sideband
  input wire [31:0] avs_address,
  input wire [5:0] avs_am,
  input wire [1:0] avs_byteenable,
  input wire avs_read,
  input wire avs_write,
  input wire [15:0] avs_writedata,
  output wire [15:0] avs_readdata,
  output wire avs_waitrequest,
  output wire [1:0] avs_response,
  // Jumper fields
  input wire [24:0] base_jmp,
  input wire [1:0] am_sel_jmp,
  // External update triggers
  input wire trig_front,
  input wire trig_back,
  // Converter side
  output wire dac_wr,
  output wire [CHW-1:0] dac_chan,
  output wire [11:0] dac_code,
  output wire [2:0] range_sel,
  output wire field_connect,
  output wire led_on,
  // Measurement converter
  output wire adc_start,
  input wire adc_valid,
  input wire [15:0] adc_data
);

  localparam IDXW = CHW + 3;
  localparam U_IDLE = 2'b01;
  localparam U_APPLY = 2'b10;
  localparam C_IDLE = 3'b001;
  localparam C_DRIVE = 3'b010;
  localparam C_WAIT = 3'b100;

  function [15:0] merge;
    input [15:0] o;
    input [15:0] w;
    input [1:0] be;
    begin
      merge = {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  reg ack_ff;
  reg [15:0] rdata_ff;
  reg [1:0] resp_ff;
  reg [15:0] hold_ff [0:NCH-1];
  reg [31:0] cal_mem [0:(NRANGES << CHW)-1];
  reg [7:0] ctrl_ff;
  reg led_ff;
  reg [NCH-1:0] pend_ff;
  reg cal_go_ff;
  reg pass_ff;
  reg fail_ff;
  reg [CHW-1:0] fail_ch_ff;
  reg [2:0] fail_rng_ff;
  reg [2:0] cal_st_ff;

  wire am_np;
  wire am_su;
  wire am_ok;
  wire a32;
  wire a24;
  wire base_hit;
  wire hit;
  wire req;
  wire [6:0] off;
  wire [CHW-1:0] wch;
  wire is_ch;
  wire wr_do;
  wire [2:0] rng;
  wire cal_busy;
  wire [15:0] stat_word;
  wire [15:0] ctrl_word;
  reg [15:0] rd_mux;

  assign am_np = (avs_am == `AM_A32_NP) | (avs_am == `AM_A24_NP) | (avs_am == `AM_A16_NP);
  assign am_su = (avs_am == `AM_A32_SU) | (avs_am == `AM_A24_SU) | (avs_am == `AM_A16_SU);
  assign am_ok = (am_np & am_sel_jmp[0]) | (am_su & am_sel_jmp[1]);
  assign a32 = (avs_am == `AM_A32_NP) | (avs_am == `AM_A32_SU);
  assign a24 = (avs_am == `AM_A24_NP) | (avs_am == `AM_A24_SU);
  // A16 is the remaining accepted pair
  assign base_hit = a32 ? (avs_address[31:7] == base_jmp) :
                    a24 ? (avs_address[23:7] == base_jmp[16:0]) :
                    (avs_address[15:7] == base_jmp[8:0]);
  // Both lanes or one lane; no lane at all is not a transfer
  assign hit = am_ok & base_hit & (|avs_byteenable);
  assign req = avs_read | avs_write;
  assign off = avs_address[6:0];
  assign wch = off[CHW:1];
  assign is_ch = ~off[6];
  assign wr_do = ce & avs_write & ack_ff & hit;
  assign rng = ctrl_ff[`CTL_RNG_HI:`CTL_RNG_LO];
  assign cal_busy = ~cal_st_ff[0];
  assign ctrl_word = {7'h00, led_ff, ctrl_ff};
  assign stat_word = {5'h00, fail_rng_ff, fail_ch_ff, fail_ff, pass_ff, cal_busy};

  // One wait state: answer well inside 500 ns at 100 ns per cycle
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign avs_response = resp_ff;

  always @*
  begin
    rd_mux = 16'h0000;
    if (is_ch)
      rd_mux = hold_ff[wch];
    else if (off == `OFS_CTRL)
      rd_mux = ctrl_word;
    else if (off == `OFS_STAT)
      rd_mux = stat_word;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      resp_ff <= `RESP_OK;
    end
    else if (ce)
    begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff)
      begin
        rdata_ff <= (hit & avs_read) ? rd_mux : 16'h0000;
        resp_ff <= hit ? `RESP_OK : `RESP_DECERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and trigger

  reg [7:0] trig_cnt_ff;
  reg trig_fire;
  wire trig_lvl;
  wire sw_trig;
  wire ctrl_wr;
  wire [15:0] ctrl_new;
  wire rng_chg;
  wire cal_done;
  wire cal_clean;
  wire [NCH-1:0] pend_set;
  wire [NCH-1:0] pend_clr;
  integer i;

  assign ctrl_wr = wr_do & ~is_ch & (off == `OFS_CTRL);
  assign ctrl_new = merge(ctrl_word, avs_writedata, avs_byteenable);
  assign rng_chg = ctrl_wr & (ctrl_new[`CTL_RNG_HI:`CTL_RNG_LO] != rng) &
                   (ctrl_new[`CTL_RNG_HI:`CTL_RNG_LO] < NRANGES);
  assign sw_trig = wr_do & ~is_ch & (off == `OFS_CMD) & avs_writedata[`CMD_TRIG];
  // Active-low when polarity bit set
  assign trig_lvl = (ctrl_ff[`CTL_TSRC] ? trig_back : trig_front) ^ ctrl_ff[`CTL_TPOL];

  // Pulse narrower than the minimum width is taken as noise
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trig_cnt_ff <= 8'h00;
      trig_fire <= 1'b0;
    end
    else if (ce)
    begin
      trig_fire <= trig_lvl & (trig_cnt_ff == `TRIG_MIN_CYC - 1);
      if (!trig_lvl)
        trig_cnt_ff <= 8'h00;
      else if (trig_cnt_ff != `TRIG_MIN_CYC)
        trig_cnt_ff <= trig_cnt_ff + 8'h01;
    end
  end

  // Direct mode queues the written channel; trigger, range or new table queues all
  assign pend_set = (sw_trig | trig_fire | rng_chg | cal_done) ? {NCH{1'b1}} :
                    (wr_do & is_ch & ~ctrl_ff[`CTL_SYNC]) ? ({{(NCH-1){1'b0}}, 1'b1} << wch) :
                    {NCH{1'b0}};

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < NCH; i = i + 1)
        hold_ff[i] <= 16'h0000;
      ctrl_ff <= `CTL_RESET;
      led_ff <= 1'b1;
      pend_ff <= {NCH{1'b0}};
    end
    else if (ce)
    begin
      if (wr_do & is_ch)
        hold_ff[wch] <= merge(hold_ff[wch], avs_writedata, avs_byteenable);
      if (ctrl_wr)
      begin
        ctrl_ff[`CTL_FMT] <= ctrl_new[`CTL_FMT];
        ctrl_ff[`CTL_SYNC] <= ctrl_new[`CTL_SYNC];
        ctrl_ff[`CTL_TSRC] <= ctrl_new[`CTL_TSRC];
        ctrl_ff[`CTL_TPOL] <= ctrl_new[`CTL_TPOL];
        ctrl_ff[`CTL_ONLINE] <= ctrl_new[`CTL_ONLINE];
        if (ctrl_new[`CTL_RNG_HI:`CTL_RNG_LO] < NRANGES)
          ctrl_ff[`CTL_RNG_HI:`CTL_RNG_LO] <= ctrl_new[`CTL_RNG_HI:`CTL_RNG_LO];
      end
      // Software write wins over the automatic clear of the same edge
      if (ctrl_wr)
        led_ff <= ctrl_new[`CTL_LED];
      else if (cal_clean)
        led_ff <= 1'b0;
      pend_ff <= (pend_ff & ~pend_clr) | pend_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output update engine

  reg [1:0] upd_st_ff;
  reg [CHW-1:0] ptr_ff;
  reg [CHW-1:0] uch_ff;
  reg [31:0] memrd_ff;
  reg dac_wr_ff;
  reg [CHW-1:0] dac_chan_ff;
  reg [11:0] dac_code_ff;
  reg [CHW-1:0] cal_ch_ff;
  reg [2:0] cal_rng_ff;
  wire upd_go;
  wire [11:0] corr;
  wire cal_drive;

  assign upd_go = upd_st_ff[0] & ~cal_busy & pend_ff[ptr_ff];
  assign pend_clr = upd_go ? ({{(NCH-1){1'b0}}, 1'b1} << ptr_ff) : {NCH{1'b0}};
  assign cal_drive = cal_st_ff[1];

  // Table read issued with the channel pick, used one cycle later
  always @(posedge core_clk)
  begin
    if (ce)
      memrd_ff <= cal_mem[{rng, ptr_ff}];
  end

  code_correct u_corr (
    .code(hold_ff[uch_ff]),
    .twos_fmt(ctrl_ff[`CTL_FMT]),
    .ofs(memrd_ff[31:16]),
    .gerr(memrd_ff[15:0]),
    .corr(corr)
  );

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      upd_st_ff <= U_IDLE;
      ptr_ff <= {CHW{1'b0}};
      uch_ff <= {CHW{1'b0}};
      dac_wr_ff <= 1'b0;
      dac_chan_ff <= {CHW{1'b0}};
      dac_code_ff <= 12'h000;
    end
    else if (ce)
    begin
      dac_wr_ff <= 1'b0;
      case (upd_st_ff)
        U_IDLE:
        begin
          if (upd_go)
          begin
            uch_ff <= ptr_ff;
            upd_st_ff <= U_APPLY;
          end
          ptr_ff <= ptr_ff + {{(CHW-1){1'b0}}, 1'b1};
        end
        U_APPLY:
        begin
          // Calibration may have started meanwhile; it owns the converters
          if (!cal_busy)
          begin
            dac_wr_ff <= 1'b1;
            dac_chan_ff <= uch_ff;
            dac_code_ff <= corr;
          end
          upd_st_ff <= U_IDLE;
        end
        default:
          upd_st_ff <= U_IDLE;
      endcase
      if (cal_drive)
      begin
        dac_wr_ff <= 1'b1;
        dac_chan_ff <= cal_ch_ff;
        dac_code_ff <= fail_ff ? `CAL_CODE_LO : dac_code_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Self-test and calibration

  reg cal_pt_ff;
  reg [15:0] lo_ff;
  reg adc_start_ff;
  wire cal_cmd;
  wire cal_we;
  wire cal_last;
  wire [15:0] ofs_meas;
  wire [15:0] gerr_meas;
  wire ofs_bad;
  wire gerr_bad;

  assign cal_cmd = wr_do & ~is_ch & (off == `OFS_CMD) & avs_writedata[`CMD_CAL];
  assign cal_we = ce & cal_st_ff[2] & adc_valid & cal_pt_ff;
  assign cal_last = (cal_ch_ff == NCH - 1) & (cal_rng_ff == NRANGES - 1);
  assign cal_done = cal_we & cal_last;
  // A failure on the very last point must keep the indicator lit too
  assign cal_clean = cal_done & ~(fail_ff | ofs_bad | gerr_bad);
  assign ofs_meas = lo_ff - `ADC_LO_NOM;
  assign gerr_meas = (`ADC_HI_NOM - `ADC_LO_NOM) - (adc_data - lo_ff);
  assign ofs_bad = ($signed(ofs_meas) > $signed(`OFS_LIM)) |
                   ($signed(ofs_meas) < -$signed(`OFS_LIM));
  assign gerr_bad = ($signed(gerr_meas) > $signed(`GERR_LIM)) |
                    ($signed(gerr_meas) < -$signed(`GERR_LIM));

  always @(posedge core_clk)
  begin
    if (cal_we)
      cal_mem[{cal_rng_ff, cal_ch_ff}] <= {ofs_meas, gerr_meas};
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_go_ff <= 1'b1;
      cal_st_ff <= C_IDLE;
      cal_ch_ff <= {CHW{1'b0}};
      cal_rng_ff <= 3'h0;
      cal_pt_ff <= 1'b0;
      lo_ff <= 16'h0000;
      adc_start_ff <= 1'b0;
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
      fail_ch_ff <= {CHW{1'b0}};
      fail_rng_ff <= 3'h0;
    end
    else if (ce)
    begin
      adc_start_ff <= 1'b0;
      // Command arriving at the start edge stays queued for a rerun
      cal_go_ff <= (cal_go_ff & ~cal_st_ff[0]) | cal_cmd;
      case (cal_st_ff)
        C_IDLE:
        begin
          if (cal_go_ff)
          begin
            cal_st_ff <= C_DRIVE;
            cal_ch_ff <= {CHW{1'b0}};
            cal_rng_ff <= 3'h0;
            cal_pt_ff <= 1'b0;
            pass_ff <= 1'b0;
            fail_ff <= 1'b0;
          end
        end
        C_DRIVE:
        begin
          adc_start_ff <= 1'b1;
          cal_st_ff <= C_WAIT;
        end
        C_WAIT:
        begin
          if (adc_valid & ~cal_pt_ff)
          begin
            lo_ff <= adc_data;
            cal_pt_ff <= 1'b1;
            cal_st_ff <= C_DRIVE;
          end
          else if (adc_valid)
          begin
            if ((ofs_bad | gerr_bad) & ~fail_ff)
            begin
              fail_ff <= 1'b1;
              fail_ch_ff <= cal_ch_ff;
              fail_rng_ff <= cal_rng_ff;
            end
            cal_pt_ff <= 1'b0;
            cal_ch_ff <= cal_ch_ff + {{(CHW-1){1'b0}}, 1'b1};
            if (cal_ch_ff == NCH - 1)
              cal_rng_ff <= cal_rng_ff + 3'h1;
            if (cal_last)
            begin
              pass_ff <= ~(fail_ff | ofs_bad | gerr_bad);
              cal_st_ff <= C_IDLE;
            end
            else
              cal_st_ff <= C_DRIVE;
          end
        end
        default:
          cal_st_ff <= C_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dac_wr = dac_wr_ff;
  assign dac_chan = dac_chan_ff;
  // Low point then full scale; the second point uses the high code
  assign dac_code = (cal_busy & cal_pt_ff) ? `CAL_CODE_HI :
                    cal_busy ? `CAL_CODE_LO : dac_code_ff;
  assign range_sel = cal_busy ? cal_rng_ff : rng;
  // Relay stays open while calibration drives test codes
  assign field_connect = ctrl_ff[`CTL_ONLINE] & ~cal_busy;
  assign led_on = led_ff;
  assign adc_start = adc_start_ff;

endmodule // dac_output_ctrl

// ===== testbench/dac_output_ctrl_checker.sv
module dac_output_ctrl_checker #(
  parameter NCH = 32,
  parameter CHW = 5,
  parameter NRANGES = 6
)
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Bus and jumpers
  input wire [31:0] avs_address,
  input wire [5:0] avs_am,
  input wire [1:0] avs_byteenable,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire [24:0] base_jmp,
  input wire [1:0] am_sel_jmp,
  // Converter side
  input wire [11:0] dac_code,
  input wire [2:0] range_sel,
  input wire field_connect,
  input wire led_on,
  input wire adc_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire req = avs_read | avs_write;
  wire done = req & ~avs_waitrequest;
  wire a32 = avs_am == 6'h09 || avs_am == 6'h0D;
  wire known = a32 || avs_am == 6'h39 || avs_am == 6'h3D || avs_am == 6'h29 || avs_am == 6'h2D;
  // Bit 2 of the modifier separates supervisory from nonprivileged
  wire am_ok = known && (avs_am[2] ? am_sel_jmp[1] : am_sel_jmp[0]);
  wire hit32 = a32 && am_ok && avs_address[31:7] == base_jmp && avs_byteenable != 2'h0;
  ////////////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  ack_bound_a: assert property (req |-> ##[0:4] !avs_waitrequest)
    else $error("bus answer later than 500 ns");
  refuse_am_a: assert property (done && !(am_ok && avs_byteenable != 2'h0) |->
    avs_response == 2'h3)
    else $error("foreign cycle not refused");
  accept_win_a: assert property (done && hit32 |-> avs_response == 2'h0)
    else $error("cycle inside window refused");
  led_reset_a: assert property ($rose(nrst) |-> led_on)
    else $error("indicator dark after reset");
  offline_reset_a: assert property ($rose(nrst) |-> !field_connect)
    else $error("outputs online after reset");
  cal_start_a: assert property ($rose(nrst) |-> ##[1:4] adc_start)
    else $error("calibration did not start after reset");
  cal_code_a: assert property (adc_start |-> dac_code == 12'h000 || dac_code == 12'hFFF)
    else $error("measurement without calibration code");
  offline_cal_a: assert property (adc_start |-> !field_connect)
    else $error("outputs online during calibration");
  range_ok_a: assert property (range_sel < 3'h6)
    else $error("range select out of set");
  cover property ($rose(req) ##1 avs_response == 2'h3);
  cover property (done && avs_write && hit32);
  cover property (adc_start);
endmodule // dac_output_ctrl_checker

bind dac_output_ctrl dac_output_ctrl_checker #(.NCH(NCH), .CHW(CHW), .NRANGES(NRANGES)) chk (
  .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_am(avs_am),
  .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .base_jmp(base_jmp),
  .am_sel_jmp(am_sel_jmp), .dac_code(dac_code), .range_sel(range_sel),
  .field_connect(field_connect), .led_on(led_on), .adc_start(adc_start)
);

// ===== testbench/adc_model.sv
module adc_model
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Converter side of the block
  input wire [11:0] dac_code,
  input wire [4:0] dac_chan,
  input wire adc_start,
  // Test controls
  input wire slow,
  input wire bad,
  // Measurement result
  output logic adc_valid,
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  logic [15:0] meas_ff;
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      cnt_ff <= 4'h0;
      meas_ff <= 16'h0000;
      adc_valid <= 1'b0;
      adc_data <= 16'h5A5A;
    end
    else
    begin
      adc_valid <= 1'b0;
      // Stale data toggles so it is never mistaken for a result
      adc_data <= ~adc_data;
      if (adc_start)
      begin
        cnt_ff <= slow ? 4'h6 : 4'h1;
        meas_ff <= {dac_code, 4'h0} + ((bad && dac_chan == 5'h03 && dac_code == 12'h000) ?
          16'h0400 : 16'h0000);
      end
      else if (cnt_ff != 4'h0)
      begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h1)
        begin
          adc_valid <= 1'b1;
          adc_data <= meas_ff;
        end
      end
    end
endmodule // adc_model

// ===== testbench/tb_vme_dac_output_controller.sv
module tb_vme_dac_output_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [24:0] BASE = 25'h0123457;
  logic core_clk, nrst, avs_read, avs_write, trig_front, trig_back, slow, bad;
  logic avs_waitrequest, dac_wr, field_connect, led_on, adc_start, adc_valid;
  logic [31:0] avs_address, a;
  logic [5:0] avs_am;
  logic [1:0] avs_byteenable, am_sel_jmp, avs_response, r;
  logic [15:0] avs_writedata, avs_readdata, adc_data, q;
  logic [4:0] dac_chan;
  logic [11:0] dac_code;
  logic [2:0] range_sel;
  logic [5:0] ams [6] = '{6'h09, 6'h0D, 6'h39, 6'h3D, 6'h29, 6'h2D};
  int bad_count, cmp_count;

  dac_output_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .avs_address(avs_address),
    .avs_am(avs_am), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .base_jmp(BASE),
    .am_sel_jmp(am_sel_jmp), .trig_front(trig_front), .trig_back(trig_back), .dac_wr(dac_wr),
    .dac_chan(dac_chan), .dac_code(dac_code), .range_sel(range_sel),
    .field_connect(field_connect), .led_on(led_on), .adc_start(adc_start),
    .adc_valid(adc_valid), .adc_data(adc_data));
  adc_model adc (.core_clk(core_clk), .nrst(nrst), .dac_code(dac_code), .dac_chan(dac_chan),
    .adc_start(adc_start), .slow(slow), .bad(bad), .adc_valid(adc_valid), .adc_data(adc_data));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task bus(input logic wr, input logic [31:0] ad, input logic [5:0] am, input logic [1:0] be,
    input logic [15:0] d);
    int n;
    avs_address <= ad;
    avs_am <= am;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      stop_test;
    end
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so a following request never lands in the same step
    @(posedge core_clk);
  endtask

  task wr(input logic [6:0] o, input logic [15:0] d);
    bus(1'b1, {BASE, o}, 6'h09, 2'h3, d);
  endtask

  task rd(input logic [6:0] o);
    bus(1'b0, {BASE, o}, 6'h09, 2'h3, 16'h0000);
  endtask

  task wait_cal;
    int n;
    n = 0;
    do
    begin
      rd(7'h42);
      n++;
    end
    while (q[0] !== 1'b0 && n < 5000);
    if (q[0] !== 1'b0)
    begin
      bad_count++;
      stop_test;
    end
    check({15'h0000, q[0]}, 16'h0000);
  endtask

  task wait_dac(input logic [4:0] ch, input logic [11:0] code);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      // Trigger inputs return to idle well after the qualifying width
      if (n == 12)
      begin
        trig_front <= 1'b0;
        trig_back <= 1'b1;
      end
    end
    while (!(dac_wr === 1'b1 && dac_chan === ch) && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      stop_test;
    end
    check({4'h0, dac_code}, {4'h0, code});
    // Let the rest of a full sweep drain so the next step starts quiet
    repeat (70) @(posedge core_clk);
  endtask

  task quiet;
    int c;
    c = 0;
    repeat (40)
    begin
      @(posedge core_clk);
      if (dac_wr !== 1'b0)
        c++;
    end
    check(16'(c), 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, avs_read, avs_write, trig_front, bad} = 5'h00;
    {trig_back, slow} = 2'h3;
    {avs_address, avs_am, avs_byteenable, avs_writedata} = 56'h0;
    am_sel_jmp = 2'h3;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check({15'h0000, led_on}, 16'h0001);
    check({15'h0000, field_connect}, 16'h0000);
    rd(7'h40);
    check(q, 16'h0100);
    rd(7'h42);
    check(q & 16'h0001, 16'h0001);
    wait_cal;
    check(q & 16'h0007, 16'h0002);
    check({15'h0000, led_on}, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      a = {BASE, 7'h00} + 32'(2 * i);
      a = (i < 2) ? a : (i < 4) ? (a & 32'h00FFFFFF) : (a & 32'h0000FFFF);
      bus(1'b1, a, ams[i], 2'h3, 16'h0100 + 16'(i));
      check({14'h0000, r}, 16'h0000);
      bus(1'b0, a, ams[i], 2'h3, 16'h0000);
      check(q, 16'h0100 + 16'(i));
    end
    am_sel_jmp <= 2'h1;
    bus(1'b1, {BASE, 7'h10}, 6'h0D, 2'h3, 16'h0ABC);
    check({14'h0000, r}, 16'h0003);
    am_sel_jmp <= 2'h3;
    bus(1'b1, {BASE, 7'h10}, 6'h3F, 2'h3, 16'h0ABC);
    check({14'h0000, r}, 16'h0003);
    bus(1'b1, {BASE + 25'h1, 7'h10}, 6'h09, 2'h3, 16'h0ABC);
    check({14'h0000, r}, 16'h0003);
    bus(1'b1, {BASE, 7'h10}, 6'h09, 2'h0, 16'h0ABC);
    check({14'h0000, r}, 16'h0003);
    rd(7'h10);
    check(q, 16'h0000);
    wr(7'h00, 16'h0234);
    bus(1'b1, {BASE, 7'h00}, 6'h09, 2'h1, 16'hEE77);
    bus(1'b1, {BASE, 7'h00}, 6'h09, 2'h2, 16'h05EE);
    rd(7'h00);
    check(q, 16'h0577);
    wr(7'h40, 16'h0088);
    check({15'h0000, field_connect}, 16'h0001);
    check({13'h0000, range_sel}, 16'h0002);
    repeat (40) @(posedge core_clk);
    wr(7'h0A, 16'h0123);
    wait_dac(5'h05, 12'h123);
    wr(7'h40, 16'h0089);
    repeat (40) @(posedge core_clk);
    wr(7'h0A, 16'h0123);
    wait_dac(5'h05, 12'h923);
    wr(7'h40, 16'h008A);
    repeat (40) @(posedge core_clk);
    wr(7'h0C, 16'h0456);
    quiet;
    wr(7'h44, 16'h0001);
    wait_dac(5'h06, 12'h456);
    wr(7'h0C, 16'h0457);
    trig_front <= 1'b1;
    repeat (5) @(posedge core_clk);
    trig_front <= 1'b0;
    quiet;
    trig_front <= 1'b1;
    wait_dac(5'h06, 12'h457);
    wr(7'h40, 16'h00EA);
    wr(7'h0E, 16'h0321);
    trig_back <= 1'b0;
    wait_dac(5'h07, 12'h321);
    wr(7'h40, 16'h01EA);
    check({15'h0000, led_on}, 16'h0001);
    wr(7'h40, 16'h00EA);
    check({15'h0000, led_on}, 16'h0000);
    rd(7'h44);
    check(q, 16'h0000);
    bad <= 1'b1;
    slow <= 1'b0;
    wr(7'h44, 16'h0002);
    rd(7'h42);
    check(q & 16'h0001, 16'h0001);
    wait_cal;
    check(q & 16'h00FE, 16'h001C);
    // Reset after the failed run: controls back to default, failing rerun keeps the indicator lit
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(7'h40);
    check(q, 16'h0100);
    wait_cal;
    check(q & 16'h0007, 16'h0004);
    check({15'h0000, led_on}, 16'h0001);
    stop_test;
  end
endmodule // tb_vme_dac_output_controller
